// >>> rtl/prog_seq_pkg.sv
// constants shared by the programmer sequencer and its link engine
// assumes a 50 MHz system clock
package prog_seq_pkg;
  localparam int unsigned CLK_HZ            = 50000000;
  localparam int unsigned START_MIN_MS      = 30;
  localparam int unsigned START_MIN_CYC     =
    (CLK_HZ / 1000) * START_MIN_MS;
  localparam int unsigned MS_CYC            = CLK_HZ / 1000;
  localparam int unsigned OSC_HZ            = 11000000;
  // half period of target clock, rounded down: 50/11/2 -> 2 cycles
  localparam int unsigned OSC_HALF_CYC      = CLK_HZ / OSC_HZ / 2;
  localparam logic [15:0] RST_ACTIVE_MS_DEF = 16'h0014;
  localparam logic [15:0] RST_INACT_MS_DEF  = 16'h01F4;
  localparam int unsigned LINK_HALF_CYC     = 25;
  localparam int unsigned LINK_TIMEOUT_CYC  = 50000;

  // wishbone register map, word aligned
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_STATUS    = 8'h04;
  localparam logic [7:0] REG_RST_TIME  = 8'h08;
  localparam logic [7:0] REG_RANGE     = 8'h0C;

  localparam int unsigned CTRL_ERASE_EN = 0;
  localparam int unsigned CTRL_IGN_OPT  = 1;
  localparam int unsigned CTRL_PUSHPULL = 2;
  localparam int unsigned CTRL_SW_START = 3;
  localparam logic [3:0]  CTRL_RESET    = 4'h5;

  localparam logic [31:0] RANGE_RESET   = 32'h00000000;

  // commands to the link engine
  typedef enum logic [3:0] {
    CMD_LOAD    = 4'h1,
    CMD_ERASE   = 4'h2,
    CMD_PROGRAM = 4'h4,
    CMD_VERIFY  = 4'h8
  } link_cmd_t;
endpackage

// >>> rtl/link_engine.sv
// in-circuit link engine: shifts a command byte out on open-drain lines
// and samples one result bit back; assumes target holds data for result
`timescale 1ns/1ps
module link_engine (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    go,
  input  wire prog_seq_pkg::link_cmd_t cmd,
  input  wire logic                    data_in,
  output logic                         data_out,
  output logic                         data_oe_n,
  output logic                         clk_oe_n,
  output logic                         done,
  output logic                         ok
);
  logic [7:0]  sh_reg;
  logic [3:0]  bit_reg;
  logic [15:0] div_reg;
  logic [15:0] tmo_reg;
  logic        busy_reg;
  logic        phase_reg;

  // line is pulled up; low driven by enabling the open-drain output
  assign data_out = 1'b0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sh_reg    <= 8'h00;
      bit_reg   <= 4'h0;
      div_reg   <= 16'h0000;
      tmo_reg   <= 16'h0000;
      busy_reg  <= 1'b0;
      phase_reg <= 1'b0;
      data_oe_n <= 1'b1;
      clk_oe_n  <= 1'b1;
      done      <= 1'b0;
      ok        <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!busy_reg) begin
        if (go) begin
          busy_reg  <= 1'b1;
          sh_reg    <= {4'h0, cmd};
          bit_reg   <= 4'h0;
          div_reg   <= 16'h0000;
          tmo_reg   <= 16'h0000;
          phase_reg <= 1'b0;
        end
      end else if (bit_reg < 4'h8) begin
        if (div_reg == 16'(prog_seq_pkg::LINK_HALF_CYC - 1)) begin
          div_reg   <= 16'h0000;
          phase_reg <= ~phase_reg;
          if (!phase_reg) begin
            data_oe_n <= sh_reg[7];
            clk_oe_n  <= 1'b0;
          end else begin
            clk_oe_n <= 1'b1;
            sh_reg   <= {sh_reg[6:0], 1'b0};
            bit_reg  <= bit_reg + 4'h1;
          end
        end else begin
          div_reg <= div_reg + 16'h0001;
        end
      end else begin
        // wait for target to answer by pulling data low
        data_oe_n <= 1'b1;
        tmo_reg   <= tmo_reg + 16'h0001;
        if (!data_in && tmo_reg > 16'h0004) begin
          busy_reg <= 1'b0;
          done     <= 1'b1;
          ok       <= 1'b1;
        end else if (tmo_reg ==
                     16'(prog_seq_pkg::LINK_TIMEOUT_CYC)) begin
          busy_reg <= 1'b0;
          done     <= 1'b1;
          ok       <= 1'b0;
        end
      end
    end
  end
endmodule

// >>> rtl/programmer_auto_sequencer.sv
// automatic erase/program/verify sequencer of a flash programmer
// assumes one 50 MHz clock, classic wishbone slave, start pulse synchronous
//
// Operation
// - start pulse held 30 ms minimum; sequence starts on its falling edge.
// - sequence order is optional erase, then program, then verify.
// - erase step runs only when auto-erase setting is enabled.
// - busy asserts at once when sequence starts, transistor off.
// - pass output shows last result; tester samples after busy ends.
// - LED flashes green while running (here only in erase, program, verify; dark in reset and load), steady green pass, steady red fail.
// - each button press programs one target with stored settings.
// - option-ignoring entry drives free-running clock near 11 MHz.
// - option-honouring entry leaves oscillator output idle.
// - session resets target, enters link mode, loads helper, runs commands.
// - programming voltage is used for link entry and for programming.
// - target reset may be driven push-pull instead of open drain.
// - reset active and inactive times in ms, default 20 and 500.
`timescale 1ns/1ps
module programmer_auto_sequencer (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        START,
  input  wire logic        BUTTON,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  input  wire logic        WB_WE_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_CYC_I,
  output logic             WB_ACK_O,
  output logic             BUSY_ON,
  output logic             PASS_ON,
  output logic             LED_GREEN,
  output logic             LED_RED,
  output logic             TARGET_RST_N_O,
  output logic             TARGET_RST_OE_N,
  output logic             PROG_VOLTAGE_SELECT,
  output logic             TARGET_OSC_OUT,
  input  wire logic        LINK_DATA_LINE_I,
  output logic             LINK_DATA_LINE_O,
  output logic             LINK_DATA_LINE_OE_N,
  input  wire logic        LINK_CLOCK_LINE_I,
  output logic             LINK_CLOCK_LINE_O,
  output logic             LINK_CLOCK_LINE_OE_N
);
  typedef enum logic [7:0] {
    S_IDLE    = 8'h01,
    S_RST_ACT = 8'h02,
    S_RST_INA = 8'h04,
    S_LOAD    = 8'h08,
    S_ERASE   = 8'h10,
    S_PROGRAM = 8'h20,
    S_VERIFY  = 8'h40,
    S_DONE    = 8'h80
  } state_t;

  state_t      state_reg;
  state_t      state_next;
  logic [3:0]  ctrl_reg;
  logic [31:0] rst_time_reg;
  logic [31:0] range_reg;
  logic [31:0] start_cnt_reg;
  logic        start_armed_reg;
  logic        start_d_reg;
  logic        button_d_reg;
  logic        go_pulse;
  logic [31:0] ms_cnt_reg;
  logic [15:0] ms_reg;
  logic        pass_reg;
  logic        ran_reg;
  logic [23:0] blink_reg;
  logic [3:0]  osc_cnt_reg;
  logic        link_go_reg;
  prog_seq_pkg::link_cmd_t link_cmd_reg;
  logic        link_done;
  logic        link_ok;
  logic        wb_hit;

  // start pulse qualification: length counted while high
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      start_d_reg     <= 1'b0;
      start_cnt_reg   <= 32'h00000000;
      start_armed_reg <= 1'b0;
      button_d_reg    <= 1'b0;
    end else begin
      start_d_reg  <= START;
      button_d_reg <= BUTTON;
      if (START) begin
        if (start_cnt_reg >= 32'(prog_seq_pkg::START_MIN_CYC - 1)) begin
          start_armed_reg <= 1'b1;
        end else begin
          start_cnt_reg <= start_cnt_reg + 32'h00000001;
        end
      end else begin
        start_cnt_reg   <= 32'h00000000;
        start_armed_reg <= 1'b0;
      end
    end
  end

  // falling edge of a long enough pulse, or button press, or software
  assign go_pulse = (start_d_reg && !START && start_armed_reg)
                 || (BUTTON && !button_d_reg)
                 || (wb_hit && WB_WE_I && WB_SEL_I[0] &&
                     WB_ADR_I == prog_seq_pkg::REG_CTRL &&
                     WB_DAT_I[prog_seq_pkg::CTRL_SW_START]);

  // millisecond timer for reset phases
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ms_cnt_reg <= 32'h00000000;
      ms_reg     <= 16'h0000;
    end else if (state_reg != state_next) begin
      ms_cnt_reg <= 32'h00000000;
      ms_reg     <= 16'h0000;
    end else if (ms_cnt_reg == 32'(prog_seq_pkg::MS_CYC - 1)) begin
      ms_cnt_reg <= 32'h00000000;
      ms_reg     <= ms_reg + 16'h0001;
    end else begin
      ms_cnt_reg <= ms_cnt_reg + 32'h00000001;
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        if (go_pulse) begin
          state_next = S_RST_ACT;
        end
      end
      S_RST_ACT: begin
        if (ms_reg == rst_time_reg[15:0]) begin
          state_next = S_RST_INA;
        end
      end
      S_RST_INA: begin
        if (ms_reg == rst_time_reg[31:16]) begin
          state_next = S_LOAD;
        end
      end
      S_LOAD: begin
        if (link_done) begin
          if (!link_ok) begin
            state_next = S_DONE;
          end else if (ctrl_reg[prog_seq_pkg::CTRL_ERASE_EN]) begin
            state_next = S_ERASE;
          end else begin
            state_next = S_PROGRAM;
          end
        end
      end
      S_ERASE: begin
        if (link_done) begin
          state_next = link_ok ? S_PROGRAM : S_DONE;
        end
      end
      S_PROGRAM: begin
        if (link_done) begin
          state_next = link_ok ? S_VERIFY : S_DONE;
        end
      end
      S_VERIFY: begin
        if (link_done) begin
          state_next = S_DONE;
        end
      end
      S_DONE: begin
        state_next = S_IDLE;
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_reg <= S_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // link command issue, one per step
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      link_go_reg  <= 1'b0;
      link_cmd_reg <= prog_seq_pkg::CMD_LOAD;
    end else begin
      link_go_reg <= 1'b0;
      if (state_reg != state_next) begin
        case (state_next)
          S_LOAD: begin
            link_go_reg  <= 1'b1;
            link_cmd_reg <= prog_seq_pkg::CMD_LOAD;
          end
          S_ERASE: begin
            link_go_reg  <= 1'b1;
            link_cmd_reg <= prog_seq_pkg::CMD_ERASE;
          end
          S_PROGRAM: begin
            link_go_reg  <= 1'b1;
            link_cmd_reg <= prog_seq_pkg::CMD_PROGRAM;
          end
          S_VERIFY: begin
            link_go_reg  <= 1'b1;
            link_cmd_reg <= prog_seq_pkg::CMD_VERIFY;
          end
          default: begin
            link_go_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // link clock enable is taken straight from the engine flop: an extra
  // stage here would let the data release overtake the last clock rise
  link_engine link_engine_i (
    .clk       (CLK),
    .rst       (RST),
    .go        (link_go_reg),
    .cmd       (link_cmd_reg),
    .data_in   (LINK_DATA_LINE_I),
    .data_out  (),
    .data_oe_n (LINK_DATA_LINE_OE_N),
    .clk_oe_n  (LINK_CLOCK_LINE_OE_N),
    .done      (link_done),
    .ok        (link_ok)
  );

  // result and busy: pass written one edge before busy is released,
  // so a tester seeing busy passive always sees the fresh result
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pass_reg <= 1'b0;
      ran_reg  <= 1'b0;
      BUSY_ON  <= 1'b1;
      PASS_ON  <= 1'b0;
    end else begin
      BUSY_ON <= (state_next == S_IDLE);
      if (state_reg == S_VERIFY && link_done) begin
        pass_reg <= link_ok;
        PASS_ON  <= link_ok;
        ran_reg  <= 1'b1;
      end else if (state_next == S_DONE && state_reg != S_VERIFY) begin
        pass_reg <= 1'b0;
        PASS_ON  <= 1'b0;
        ran_reg  <= 1'b1;
      end else if (go_pulse && state_reg == S_IDLE) begin
        PASS_ON <= 1'b0;
      end
    end
  end

  // status led; flash rate ~3 Hz from a free counter
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      blink_reg <= 24'h000000;
      LED_GREEN <= 1'b0;
      LED_RED   <= 1'b0;
    end else begin
      blink_reg <= blink_reg + 24'h000001;
      if (state_reg == S_ERASE || state_reg == S_PROGRAM ||
          state_reg == S_VERIFY) begin
        LED_GREEN <= blink_reg[23];
        LED_RED   <= 1'b0;
      end else if (state_reg == S_IDLE && ran_reg) begin
        LED_GREEN <= pass_reg;
        LED_RED   <= ~pass_reg;
      end else begin
        LED_GREEN <= 1'b0;
        LED_RED   <= 1'b0;
      end
    end
  end

  // target pins
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      TARGET_RST_N_O       <= 1'b0;
      TARGET_RST_OE_N      <= 1'b0;
      PROG_VOLTAGE_SELECT  <= 1'b0;
      LINK_DATA_LINE_O     <= 1'b0;
      LINK_CLOCK_LINE_O    <= 1'b0;
    end else begin
      TARGET_RST_N_O <= (state_reg != S_RST_ACT);
      // open drain only pulls low; push-pull drives both levels
      TARGET_RST_OE_N <= ctrl_reg[prog_seq_pkg::CTRL_PUSHPULL] ? 1'b0
                       : (state_reg != S_RST_ACT);
      // raised together with target reset and held until done, so target enters link mode
      PROG_VOLTAGE_SELECT <= (state_reg != S_IDLE) &&
                             (state_reg != S_DONE);
      LINK_DATA_LINE_O     <= 1'b0;
      LINK_CLOCK_LINE_O    <= 1'b0;
    end
  end

  // target oscillator: 50/4 = 12.5 MHz, nearest even division to 11
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      osc_cnt_reg    <= 4'h0;
      TARGET_OSC_OUT <= 1'b0;
    end else if (!ctrl_reg[prog_seq_pkg::CTRL_IGN_OPT]) begin
      osc_cnt_reg    <= 4'h0;
      TARGET_OSC_OUT <= 1'b0;
    end else if (osc_cnt_reg == 4'(prog_seq_pkg::OSC_HALF_CYC - 1)) begin
      osc_cnt_reg    <= 4'h0;
      TARGET_OSC_OUT <= ~TARGET_OSC_OUT;
    end else begin
      osc_cnt_reg <= osc_cnt_reg + 4'h1;
    end
  end

  // wishbone slave, ack one cycle after request, dropped next cycle
  assign wb_hit = WB_CYC_I && WB_STB_I && !WB_ACK_O;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      WB_ACK_O     <= 1'b0;
      WB_DAT_O     <= 32'h00000000;
      ctrl_reg     <= prog_seq_pkg::CTRL_RESET;
      rst_time_reg <= {prog_seq_pkg::RST_INACT_MS_DEF,
                       prog_seq_pkg::RST_ACTIVE_MS_DEF};
      range_reg    <= prog_seq_pkg::RANGE_RESET;
    end else begin
      WB_ACK_O <= wb_hit;
      if (wb_hit && WB_WE_I) begin
        if (WB_ADR_I == prog_seq_pkg::REG_CTRL) begin
          if (WB_SEL_I[0]) begin
            ctrl_reg <= {1'b0, WB_DAT_I[2:0]};
          end
        end else if (WB_ADR_I == prog_seq_pkg::REG_RST_TIME) begin
          if (WB_SEL_I[0]) rst_time_reg[7:0]   <= WB_DAT_I[7:0];
          if (WB_SEL_I[1]) rst_time_reg[15:8]  <= WB_DAT_I[15:8];
          if (WB_SEL_I[2]) rst_time_reg[23:16] <= WB_DAT_I[23:16];
          if (WB_SEL_I[3]) rst_time_reg[31:24] <= WB_DAT_I[31:24];
        end else if (WB_ADR_I == prog_seq_pkg::REG_RANGE) begin
          if (WB_SEL_I[0]) range_reg[7:0]   <= WB_DAT_I[7:0];
          if (WB_SEL_I[1]) range_reg[15:8]  <= WB_DAT_I[15:8];
          if (WB_SEL_I[2]) range_reg[23:16] <= WB_DAT_I[23:16];
          if (WB_SEL_I[3]) range_reg[31:24] <= WB_DAT_I[31:24];
        end
      end
      if (wb_hit && !WB_WE_I) begin
        if (WB_ADR_I == prog_seq_pkg::REG_CTRL) begin
          WB_DAT_O <= {28'h0000000, ctrl_reg};
        end else if (WB_ADR_I == prog_seq_pkg::REG_STATUS) begin
          WB_DAT_O <= {21'h00000, ran_reg, pass_reg, ~BUSY_ON, state_reg};
        end else if (WB_ADR_I == prog_seq_pkg::REG_RST_TIME) begin
          WB_DAT_O <= rst_time_reg;
        end else if (WB_ADR_I == prog_seq_pkg::REG_RANGE) begin
          WB_DAT_O <= range_reg;
        end else begin
          WB_DAT_O <= 32'h00000000;
        end
      end
    end
  end
endmodule

// >>> bench/prog_seq_checker_properties.sv
// port checker of the programmer sequencer top
// assumes one clock domain and an async active-high reset
`timescale 1ns/1ps
module prog_seq_checker (
  input wire logic CLK,
  input wire logic RST,
  input wire logic BUTTON,
  input wire logic WB_STB_I,
  input wire logic WB_CYC_I,
  input wire logic WB_ACK_O,
  input wire logic BUSY_ON,
  input wire logic PASS_ON,
  input wire logic LED_GREEN,
  input wire logic LED_RED,
  input wire logic TARGET_RST_N_O,
  input wire logic TARGET_RST_OE_N,
  input wire logic PROG_VOLTAGE_SELECT,
  input wire logic LINK_DATA_LINE_OE_N,
  input wire logic LINK_CLOCK_LINE_OE_N
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  wb_ack_a: assert property (
    WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("bus request not acknowledged");
  ack_pulse_a: assert property (
    WB_ACK_O |=> !WB_ACK_O)
    else $error("acknowledge longer than one cycle");
  busy_start_a: assert property (
    $rose(BUTTON) && BUSY_ON |-> ##[1:4] !BUSY_ON)
    else $error("busy not raised after button");
  pass_update_a: assert property (
    $changed(PASS_ON) |-> !BUSY_ON)
    else $error("pass changed outside a run");
  led_result_a: assert property (
    $rose(BUSY_ON) |=> LED_GREEN == PASS_ON && LED_RED == !PASS_ON)
    else $error("led does not show result");
  red_in_run_a: assert property (
    !BUSY_ON && $past(!BUSY_ON) |-> !LED_RED)
    else $error("red led during run");
  link_quiet_a: assert property (
    BUSY_ON && $past(BUSY_ON) |-> LINK_DATA_LINE_OE_N && LINK_CLOCK_LINE_OE_N)
    else $error("link driven while idle");
  vpp_idle_a: assert property (
    BUSY_ON && $past(BUSY_ON) |-> !PROG_VOLTAGE_SELECT)
    else $error("programming voltage while idle");
  rst_enter_a: assert property (
    $fell(BUSY_ON) |-> ##[0:3] !TARGET_RST_N_O && PROG_VOLTAGE_SELECT)
    else $error("run did not begin with reset and voltage");
  rst_driven_a: assert property (
    !TARGET_RST_N_O |-> !TARGET_RST_OE_N)
    else $error("target reset level not driven");

  run_pass_c: cover property ($rose(BUSY_ON) && PASS_ON);
  run_fail_c: cover property ($rose(BUSY_ON) && !PASS_ON);
  bus_ack_c:  cover property (WB_ACK_O);
endmodule

bind programmer_auto_sequencer prog_seq_checker checker_i (
  .CLK(CLK), .RST(RST), .BUTTON(BUTTON), .WB_STB_I(WB_STB_I),
  .WB_CYC_I(WB_CYC_I), .WB_ACK_O(WB_ACK_O), .BUSY_ON(BUSY_ON),
  .PASS_ON(PASS_ON), .LED_GREEN(LED_GREEN), .LED_RED(LED_RED),
  .TARGET_RST_N_O(TARGET_RST_N_O), .TARGET_RST_OE_N(TARGET_RST_OE_N),
  .PROG_VOLTAGE_SELECT(PROG_VOLTAGE_SELECT),
  .LINK_DATA_LINE_OE_N(LINK_DATA_LINE_OE_N),
  .LINK_CLOCK_LINE_OE_N(LINK_CLOCK_LINE_OE_N));

// >>> bench/target_model.sv
// behavioural target: takes command bytes on link clock rising edges
// assumes the bench resolves the open-drain link lines
`timescale 1ns/1ps
module target_model (
  input  wire logic       clk,
  input  wire logic       tgt_rst_n,
  input  wire logic       link_clk,
  input  wire logic       link_data,
  input  wire logic [7:0] nak_cmd,
  output logic            data_pull_n,
  output logic [7:0]      cmd_byte,
  output logic            cmd_stb
);
  logic [7:0] shift_reg = 8'h00;
  logic       clk_d     = 1'b1;
  int         nbits     = 0;
  int         wait_cnt  = 0;

  initial begin
    data_pull_n = 1'b1;
    cmd_byte = 8'h00;
    cmd_stb = 1'b0;
  end

  // upper command bits are zero, so a late release cannot corrupt them
  always @(posedge clk) begin
    clk_d <= link_clk;
    cmd_stb <= 1'b0;
    if (tgt_rst_n !== 1'b1) begin
      nbits <= 0;
      wait_cnt <= 0;
      data_pull_n <= 1'b1;
    end else if (link_clk && !clk_d) begin
      shift_reg <= {shift_reg[6:0], link_data};
      nbits <= (nbits == 7) ? 0 : nbits + 1;
      if (nbits == 7) begin
        cmd_byte <= {shift_reg[6:0], link_data};
        cmd_stb <= 1'b1;
        wait_cnt <= 1;
      end
    end else if (wait_cnt > 0) begin
      wait_cnt <= wait_cnt + 1;
      if (wait_cnt == 8 && cmd_byte != nak_cmd) begin
        data_pull_n <= 1'b0;
      end
      if (wait_cnt == 60) begin
        data_pull_n <= 1'b1;
        wait_cnt <= 0;
      end
    end
  end
endmodule

// >>> bench/test_programmer_auto_sequencer.sv
// self-checking bench of the programmer sequencer
// assumes target_model and the bound port checker
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module test_programmer_auto_sequencer;
  logic        CLK = 0, RST = 1, START = 0, BUTTON = 0;
  logic [7:0]  WB_ADR_I = 8'h00;
  logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O, seed = 32'h00004EE9, e;
  logic        WB_WE_I = 0, WB_STB_I = 0, WB_CYC_I = 0, WB_ACK_O;
  logic [3:0]  WB_SEL_I = 4'hF;
  logic        BUSY_ON, PASS_ON, LED_GREEN, LED_RED, TARGET_OSC_OUT;
  logic        TARGET_RST_N_O, TARGET_RST_OE_N, PROG_VOLTAGE_SELECT;
  logic        LINK_DATA_LINE_O, LINK_DATA_LINE_OE_N, pull_n, cmd_stb;
  logic        LINK_CLOCK_LINE_O, LINK_CLOCK_LINE_OE_N, data_w, clk_w;
  logic [7:0]  nak = 8'h00, cmd_byte, c;
  logic [31:0] rd_q[$];
  logic [7:0]  cmd_q[$];
  int          n_fail = 0, num_checks = 0, cyc = 0;

  // open-drain lines with pull-ups
  assign data_w = (LINK_DATA_LINE_OE_N ? 1'b1 : LINK_DATA_LINE_O) & pull_n;
  assign clk_w = LINK_CLOCK_LINE_OE_N ? 1'b1 : LINK_CLOCK_LINE_O;

  programmer_auto_sequencer programmer_auto_sequencer_i (
    .CLK, .RST, .START, .BUTTON, .WB_ADR_I, .WB_DAT_I, .WB_DAT_O, .WB_WE_I,
    .WB_SEL_I, .WB_STB_I, .WB_CYC_I, .WB_ACK_O, .BUSY_ON, .PASS_ON,
    .LED_GREEN, .LED_RED, .TARGET_RST_N_O, .TARGET_RST_OE_N,
    .PROG_VOLTAGE_SELECT, .TARGET_OSC_OUT, .LINK_DATA_LINE_I(data_w),
    .LINK_DATA_LINE_O, .LINK_DATA_LINE_OE_N, .LINK_CLOCK_LINE_I(clk_w),
    .LINK_CLOCK_LINE_O, .LINK_CLOCK_LINE_OE_N);

  target_model target_model_i (.clk(CLK), .tgt_rst_n(TARGET_RST_N_O),
    .link_clk(clk_w), .link_data(data_w), .nak_cmd(nak),
    .data_pull_n(pull_n), .cmd_byte(cmd_byte), .cmd_stb(cmd_stb));

  always #10 CLK = ~CLK;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    WB_ADR_I <= a;
    WB_WE_I <= w;
    WB_DAT_I <= d;
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    @(posedge CLK);
    // no local limit: only the bench timeout ends this wait
    while (WB_ACK_O !== 1'b1) @(posedge CLK);
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    rd_q.push_back(x);
    wb(a, 1'b0, 32'h0);
  endtask

  // free-running clock seen as rising edges in a 40-cycle window
  task automatic osc(input int x);
    int k;
    logic p;
    k = 0;
    p = TARGET_OSC_OUT;
    repeat (40) begin
      @(posedge CLK);
      if (TARGET_OSC_OUT && !p) k++;
      p = TARGET_OSC_OUT;
    end
    `CHK("osc rises", x, k)
  endtask

  task automatic run(input int ms, input logic od, input logic ok);
    int n;
    int x;
    n = 0;
    x = ms * prog_seq_pkg::MS_CYC;
    while (BUSY_ON !== 1'b0) @(posedge CLK);
    // reset output is launched one edge after busy falls
    while (TARGET_RST_N_O !== 1'b0) @(posedge CLK);
    while (TARGET_RST_N_O !== 1'b1) begin
      @(posedge CLK);
      n++;
    end
    `CHK("reset time", 1'b1, n + 4 >= x && n <= x + 4)
    `CHK("reset drive", od, TARGET_RST_OE_N)
    while (BUSY_ON !== 1'b1) @(posedge CLK);
    @(posedge CLK);
    `CHK("pass", ok, PASS_ON)
    `CHK("green", ok, LED_GREEN)
    `CHK("red", !ok, LED_RED)
    `CHK("commands left", 0, cmd_q.size())
  endtask

  always @(posedge CLK) begin
    if (WB_ACK_O === 1'b1 && WB_WE_I === 1'b0 && rd_q.size() > 0) begin
      e = rd_q.pop_front();
      `CHK("read data", e, WB_DAT_O)
    end
    if (cmd_stb === 1'b1) begin
      c = (cmd_q.size() > 0) ? cmd_q.pop_front() : 8'hFF;
      `CHK("link command", c, cmd_byte)
    end
    cyc++;
    if (cyc == 112000) begin
      n_fail++;
      summarize();
    end
  end

  initial begin
    repeat (6) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    rd(prog_seq_pkg::REG_CTRL, {28'h0, prog_seq_pkg::CTRL_RESET});
    rd(prog_seq_pkg::REG_RST_TIME, {prog_seq_pkg::RST_INACT_MS_DEF,
       prog_seq_pkg::RST_ACTIVE_MS_DEF});
    rd(prog_seq_pkg::REG_RANGE, prog_seq_pkg::RANGE_RESET);
    rd(prog_seq_pkg::REG_STATUS, 32'h00000001);
    rd(8'h40, 32'h0);
    seed = lfsr(seed);
    wb(prog_seq_pkg::REG_RANGE, 1'b1, seed);
    rd(prog_seq_pkg::REG_RANGE, seed);
    // 1 ms active, 0 ms inactive keeps the run short
    wb(prog_seq_pkg::REG_RST_TIME, 1'b1, 32'h00000001);
    // a pulse well short of the minimum must not start a run
    START <= 1'b1;
    repeat (1000) @(posedge CLK);
    START <= 1'b0;
    repeat (20) @(posedge CLK);
    `CHK("busy short start", 1'b1, BUSY_ON)
    wb(prog_seq_pkg::REG_CTRL, 1'b1, 32'h7);
    osc(20 / prog_seq_pkg::OSC_HALF_CYC);
    cmd_q = {8'h01, 8'h02, 8'h04, 8'h08};
    BUTTON <= 1'b1;
    @(posedge CLK);
    BUTTON <= 1'b0;
    run(1, 1'b0, 1'b1);
    wb(prog_seq_pkg::REG_CTRL, 1'b1, 32'h0);
    osc(0);
    wb(prog_seq_pkg::REG_RST_TIME, 1'b1, 32'h00000000);
    nak <= 8'h08;
    cmd_q = {8'h01, 8'h04, 8'h08};
    wb(prog_seq_pkg::REG_CTRL, 1'b1, 32'h8);
    run(0, 1'b1, 1'b0);
    summarize();
  end
endmodule
